//--- design/ssq_idx_counter.sv
// Loadable up/down index counter used to walk register ranges.
// Assumes one clock, synchronous active-high reset and a clock enable.

module ssq_idx_counter #(
    parameter int W = 6
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // Control
    input wire logic load_in,
    input wire logic [W-1:0] load_val_in,
    input wire logic step_in,
    input wire logic up_in,
    // Value
    output logic [W-1:0] count_out
);

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count_out <= '0;
        end else if (ce_in) begin
            if (load_in) begin
                count_out <= load_val_in;
            end else if (step_in) begin
                count_out <= up_in ? W'(count_out + 1'b1) : W'(count_out - 1'b1);
            end
        end
    end

endmodule : ssq_idx_counter

//--- design/ssq_pkg.sv
// Constants, encodings and states shared by the stack push/pop sequencer.
// Assumes a 32-bit word machine with a downward-growing stack.
//
// Function
// - Single push writes at stack pointer minus four, which becomes the stack pointer.
// - Pop loads the word at the stack pointer, then adds four to it.
// - Unaligned stack pointer raises an exception and aborts the instruction.
// - Push or pop of subroutine return register leaves interrupt enable alone.
// - Pushing interrupt return enables interrupts; popping it disables them.
// - Popping into the stack pointer raises an undefined-instruction exception.
// - Protected system registers need supervisor mode, else protection violation.
// - Multiple ranges end at the top data or pointer register; limits 0-7, 0-5.
// - Multiple push saves lowest index first, data registers before pointers.
// - Interrupts stay pending from first multiple write until all writes finish.
// - Exception in multiple transfer restores the original stack pointer.
// - Only data 0-7 and pointer 0-5; stack and frame pointers excluded.
// - These instructions issue alone and are 16-bit only.
// - A pop never writes memory, so the popped word stays.
// - Multiple push takes one stack write per register in range.
// - Multiple pop goes highest index down, pointers first, post-incrementing.

package ssq_pkg;

    // ----------------------------------------------------------------
    // Operations, register indices
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_PUSH = 2'h0,
        OP_POP = 2'h1,
        OP_PUSHM = 2'h2,
        OP_POPM = 2'h3
    } ssq_op_type;

    localparam logic [5:0] REG_D_MAX = 6'h07;
    localparam logic [5:0] REG_P_BASE = 6'h08;
    localparam logic [5:0] REG_P_MAX = 6'h0D;
    localparam logic [5:0] REG_FRAME_PTR = 6'h0E;
    localparam logic [5:0] REG_STACK_PTR = 6'h0F;
    localparam logic [5:0] REG_SUBR_RET = 6'h10;
    localparam logic [5:0] REG_INT_RET = 6'h11;
    localparam logic [5:0] REG_EXC_RET = 6'h12;
    localparam logic [5:0] REG_NMI_RET = 6'h13;
    localparam logic [5:0] REG_EMU_RET = 6'h14;
    localparam logic [5:0] REG_USER_SP = 6'h15;
    localparam logic [5:0] REG_SEQ_STAT = 6'h16;
    localparam logic [5:0] REG_SYS_CFG = 6'h17;

    localparam logic [2:0] PLIM_MAX = 3'h5;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] SP_RESET = 32'h0000_0000;
    localparam logic IE_RESET = 1'b0;

    // ----------------------------------------------------------------
    // Exceptions and states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        EXC_NONE = 3'h0,
        EXC_UNDEF = 3'h1,
        EXC_PROT = 3'h2,
        EXC_ALIGN = 3'h3,
        EXC_BUS = 3'h4
    } ssq_exc_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_MEM = 3'b100
    } ssq_state_type;

endpackage : ssq_pkg

//--- design/ssq_stack_seq.sv
// Stack push/pop sequencer: single and multiple register push and pop.
// Assumes a register file with combinational read and a data memory port
// that answers each held request with a one-cycle ack, optionally with err.

module ssq_stack_seq
    import ssq_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    // Decoded instruction
    input wire logic cmd_valid_in,
    input wire logic [1:0] cmd_op_in,
    input wire logic [5:0] cmd_reg_in,
    input wire logic [2:0] cmd_dlim_in,
    input wire logic [2:0] cmd_plim_in,
    input wire logic cmd_use_d_in,
    input wire logic cmd_use_p_in,
    input wire logic cmd_parallel_in,
    input wire logic cmd_long_in,
    input wire logic supervisor_in,
    output logic cmd_ready_out,
    output logic done_out,
    // Stack pointer load from the core
    input wire logic sp_load_en_in,
    input wire logic [31:0] sp_load_val_in,
    output logic [31:0] stack_ptr_out,
    // Register file
    output logic [5:0] rf_rd_idx_out,
    input wire logic [31:0] rf_rd_data_in,
    output logic rf_wr_en_out,
    output logic [5:0] rf_wr_idx_out,
    output logic [31:0] rf_wr_data_out,
    // Data memory
    output logic mem_req_out,
    output logic mem_we_out,
    output logic [31:0] mem_addr_out,
    output logic [31:0] mem_wdata_out,
    input wire logic mem_ack_in,
    input wire logic mem_err_in,
    input wire logic [31:0] mem_rdata_in,
    // Interrupt system and exceptions
    input wire logic irq_in,
    output logic irq_deliver_out,
    output logic irq_hold_out,
    output logic int_enable_out,
    output logic exc_valid_out,
    output logic [2:0] exc_code_out
);

    // ----------------------------------------------------------------
    // Instruction context
    // ----------------------------------------------------------------
    ssq_state_type state, next_state;
    ssq_op_type op_q;
    ssq_exc_type next_exc;
    logic [5:0] reg_q, idx, first_idx, jump_idx;
    logic [2:0] dlim_q, plim_q;
    logic [31:0] sp_saved, next_sp;
    logic use_d_q, use_p_q, accept, issue_ok, fire, fire_ok;
    logic is_last, do_jump, is_push_q, cmd_multi, next_hold;

    assign accept = cmd_valid_in && cmd_ready_out;
    assign issue_ok = accept && (next_exc == EXC_NONE);
    assign fire = (state == ST_MEM) && mem_ack_in;
    assign fire_ok = fire && !mem_err_in;
    assign is_push_q = (op_q == OP_PUSH) || (op_q == OP_PUSHM);
    assign cmd_multi = cmd_op_in[1];

    // ----------------------------------------------------------------
    // Issue checks
    // ----------------------------------------------------------------
    always_comb begin
        next_exc = EXC_NONE;
        if (cmd_parallel_in || cmd_long_in) begin
            next_exc = EXC_UNDEF;
        end else if (cmd_op_in == OP_POP && cmd_reg_in == REG_STACK_PTR) begin
            next_exc = EXC_UNDEF;
        end else if (cmd_multi && ((!cmd_use_d_in && !cmd_use_p_in) || cmd_plim_in > PLIM_MAX)) begin
            next_exc = EXC_UNDEF;
        end else if (!cmd_multi && !supervisor_in && cmd_reg_in >= REG_INT_RET &&
                     cmd_reg_in <= REG_SYS_CFG) begin
            next_exc = EXC_PROT;
        end else if (stack_ptr_out[1:0] != 2'h0) begin
            // Stepping by whole words keeps a multiple transfer aligned once it starts
            next_exc = EXC_ALIGN;
        end
    end

    // ----------------------------------------------------------------
    // Register range walk
    // ----------------------------------------------------------------
    always_comb begin
        case (ssq_op_type'(cmd_op_in))
            OP_PUSHM: first_idx = cmd_use_d_in ? {3'h0, cmd_dlim_in} :
                                  6'(REG_P_BASE + cmd_plim_in);
            OP_POPM: first_idx = cmd_use_p_in ? REG_P_MAX : REG_D_MAX;
            default: first_idx = cmd_reg_in;
        endcase
    end
    always_comb begin
        is_last = 1'b1;
        do_jump = 1'b0;
        jump_idx = 6'(REG_P_BASE + plim_q);
        case (op_q)
            OP_PUSHM: begin
                is_last = (idx == (use_p_q ? REG_P_MAX : REG_D_MAX));
                do_jump = (idx == REG_D_MAX) && use_p_q;
            end
            OP_POPM: begin
                is_last = (idx == (use_d_q ? {3'h0, dlim_q} : 6'(REG_P_BASE + plim_q)));
                do_jump = (idx == 6'(REG_P_BASE + plim_q)) && use_d_q;
                jump_idx = REG_D_MAX;
            end
            default: is_last = 1'b1;
        endcase
    end
    ssq_idx_counter #(.W(6)) u_idx (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .ce_in(ce_in),
        .load_in(issue_ok || (fire_ok && !is_last && do_jump)),
        .load_val_in(issue_ok ? first_idx : jump_idx),
        .step_in(fire_ok && !is_last),
        .up_in(is_push_q),
        .count_out(idx)
    );
    assign rf_rd_idx_out = idx;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (issue_ok) begin
                    next_state = cmd_op_in[0] ? ST_MEM : ST_READ;
                end
            end
            ST_READ: next_state = ST_MEM;
            ST_MEM: begin
                if (fire) begin
                    if (mem_err_in || is_last) begin
                        next_state = ST_IDLE;
                    end else begin
                        next_state = is_push_q ? ST_READ : ST_MEM;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state <= ST_IDLE;
            cmd_ready_out <= 1'b0;
        end else if (ce_in) begin
            state <= next_state;
            cmd_ready_out <= (next_state == ST_IDLE);
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            op_q <= OP_PUSH;
            reg_q <= 6'h00;
            dlim_q <= 3'h0;
            plim_q <= 3'h0;
            use_d_q <= 1'b0;
            use_p_q <= 1'b0;
            sp_saved <= SP_RESET;
        end else if (ce_in && issue_ok) begin
            op_q <= ssq_op_type'(cmd_op_in);
            reg_q <= cmd_reg_in;
            dlim_q <= cmd_dlim_in;
            plim_q <= cmd_plim_in;
            use_d_q <= cmd_use_d_in;
            use_p_q <= cmd_use_p_in;
            sp_saved <= stack_ptr_out;
        end
    end

    // ----------------------------------------------------------------
    // Stack pointer
    // ----------------------------------------------------------------
    always_comb begin
        next_sp = stack_ptr_out;
        if (state == ST_IDLE && sp_load_en_in && !accept) begin
            next_sp = sp_load_val_in;
        end else if (fire && mem_err_in) begin
            // Restart after the exception needs the original pointer back
            next_sp = sp_saved;
        end else if (fire_ok && is_push_q) begin
            next_sp = mem_addr_out;
        end else if (fire_ok) begin
            next_sp = stack_ptr_out + WORD_BYTES;
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            stack_ptr_out <= SP_RESET;
        end else if (ce_in) begin
            stack_ptr_out <= next_sp;
        end
    end

    // ----------------------------------------------------------------
    // Memory port
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mem_req_out <= 1'b0;
            mem_we_out <= 1'b0;
            mem_addr_out <= 32'h0000_0000;
            mem_wdata_out <= 32'h0000_0000;
        end else if (ce_in) begin
            mem_req_out <= (next_state == ST_MEM);
            if (next_state == ST_MEM && (state != ST_MEM || fire)) begin
                if (state == ST_READ) begin
                    mem_we_out <= 1'b1;
                    mem_addr_out <= next_sp - WORD_BYTES;
                end else begin
                    mem_we_out <= 1'b0;
                    mem_addr_out <= next_sp;
                end
            end
            if (state == ST_READ) begin
                mem_wdata_out <= (idx == REG_STACK_PTR) ? stack_ptr_out : rf_rd_data_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register file write-back
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rf_wr_en_out <= 1'b0;
            rf_wr_idx_out <= 6'h00;
            rf_wr_data_out <= 32'h0000_0000;
        end else if (ce_in) begin
            rf_wr_en_out <= fire_ok && !is_push_q;
            if (fire_ok && !is_push_q) begin
                rf_wr_idx_out <= idx;
                rf_wr_data_out <= mem_rdata_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // Completion, exceptions, interrupt system
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            done_out <= 1'b0;
            exc_valid_out <= 1'b0;
            exc_code_out <= EXC_NONE;
        end else if (ce_in) begin
            done_out <= fire_ok && is_last;
            exc_valid_out <= (accept && next_exc != EXC_NONE) || (fire && mem_err_in);
            if (accept && next_exc != EXC_NONE) begin
                exc_code_out <= next_exc;
            end else if (fire && mem_err_in) begin
                exc_code_out <= EXC_BUS;
            end
        end
    end
    // Only the interrupt return register touches the enable
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            int_enable_out <= IE_RESET;
        end else if (ce_in && fire_ok && is_last && !op_q[1] && reg_q == REG_INT_RET) begin
            int_enable_out <= (op_q == OP_PUSH);
        end
    end
    // Hold rises with the first request; in idle op_q is stale, so the taken op decides
    assign next_hold = (state == ST_IDLE ? cmd_multi : op_q[1]) && next_state != ST_IDLE &&
                       (next_state == ST_MEM || irq_hold_out);
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            irq_hold_out <= 1'b0;
            irq_deliver_out <= 1'b0;
        end else if (ce_in) begin
            irq_hold_out <= next_hold;
            irq_deliver_out <= irq_in && int_enable_out && !next_hold;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in || !ce_in);

    sequence s_push_ack;
        mem_req_out && mem_we_out && mem_ack_in && !mem_err_in;
    endsequence
    sequence s_pop_ack;
        mem_req_out && !mem_we_out && mem_ack_in && !mem_err_in;
    endsequence
    a_push_addr_below: assert property (mem_req_out && mem_we_out |->
        mem_addr_out == stack_ptr_out - WORD_BYTES) else $error("push address not sp-4");
    a_push_sp_follow: assert property (s_push_ack |=>
        stack_ptr_out == $past(mem_addr_out)) else $error("sp not moved to push word");
    a_pop_sp_inc: assert property (s_pop_ack |=>
        stack_ptr_out == $past(stack_ptr_out) + WORD_BYTES) else $error("pop sp not +4");
    a_pop_no_write: assert property (mem_req_out && !is_push_q |->
        !mem_we_out) else $error("pop wrote memory");
    a_align_reject: assert property (accept && !cmd_parallel_in && !cmd_long_in &&
        next_exc != EXC_UNDEF && next_exc != EXC_PROT && stack_ptr_out[1:0] != 2'h0 |=>
        exc_valid_out && exc_code_out == EXC_ALIGN && !mem_req_out)
        else $error("unaligned sp not rejected");
    a_subr_ret_ie: assert property (fire_ok && is_last && reg_q == REG_SUBR_RET |=>
        $stable(int_enable_out)) else $error("subroutine return changed ie");
    a_int_ret_ie: assert property (fire_ok && is_last && !op_q[1] &&
        reg_q == REG_INT_RET |=> int_enable_out == (op_q == OP_PUSH))
        else $error("ie not set by int return");
    a_pop_sp_undef: assert property (accept && cmd_op_in == OP_POP &&
        cmd_reg_in == REG_STACK_PTR |=> exc_valid_out && exc_code_out == EXC_UNDEF)
        else $error("pop into sp accepted");
    a_user_protect: assert property (accept && next_exc == EXC_PROT |=>
        exc_valid_out && exc_code_out == EXC_PROT && cmd_ready_out)
        else $error("protected access not trapped");
    a_push_order: assert property (fire_ok && !is_last && op_q == OP_PUSHM &&
        idx == REG_D_MAX && use_p_q |=> idx == 6'(REG_P_BASE + plim_q))
        else $error("pointers not after data");
    a_irq_held: assert property (op_q[1] && mem_req_out |->
        irq_hold_out && !irq_deliver_out) else $error("irq delivered during multiple");
    a_abort_restore: assert property (fire && mem_err_in |=>
        stack_ptr_out == $past(sp_saved) && state == ST_IDLE)
        else $error("sp not restored on abort");
    a_issue_alone: assert property (accept && (cmd_parallel_in || cmd_long_in) |=>
        exc_valid_out && exc_code_out == EXC_UNDEF) else $error("parallel issue taken");

endmodule : ssq_stack_seq

//--- tb/ssq_mem_model.sv
// Data memory partner for the stack sequencer: word array behind a req/ack port.
// Assumes each request is held stable until acknowledged; one ack per request.
module ssq_mem_model (
    // Clock
    input wire logic clk_in,
    // Request
    input wire logic req_in,
    input wire logic we_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    // Test control
    input wire logic [31:0] lat_in,
    input wire logic [31:0] err_addr_in,
    // Answer
    output logic ack_out,
    output logic err_out,
    output logic [31:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:255];
    int cnt;
    initial begin
        ack_out = 1'b0;
        err_out = 1'b0;
        rdata_out = 32'h0000_0000;
        cnt = 0;
    end
    // ----------------------------------------------------------------
    // Answer after lat_in idle cycles
    // ----------------------------------------------------------------
    always @(posedge clk_in) begin
        ack_out <= 1'b0;
        err_out <= 1'b0;
        // Read bus toggles except on error-free read acks so a stale word never looks valid
        rdata_out <= ~rdata_out;
        if (req_in && !ack_out) begin
            if (cnt >= lat_in) begin
                cnt <= 0;
                ack_out <= 1'b1;
                if (addr_in == err_addr_in) begin
                    err_out <= 1'b1;
                end else if (we_in) begin
                    mem[addr_in[9:2]] <= wdata_in;
                end else begin
                    rdata_out <= mem[addr_in[9:2]];
                end
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule : ssq_mem_model

//--- tb/tb.sv
// Self-checking bench for the stack push/pop sequencer.
// Assumes ssq_mem_model as data memory and a register file read as rfv(index).
module tb import ssq_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, srst, cv, use_d, use_p, par, lng, sup, sp_en, irq;
    logic [1:0] op;
    logic [5:0] rg, rdidx, wridx;
    logic [2:0] dlim, plim, code;
    logic [31:0] sp_val, sp, addr, wdata, rdata, rfwd, err_addr;
    logic ready, done, hold, deliver, ie, excv, req, we, ack, err, rfwe, hold_q;
    logic [63:0] wr_q[$];
    logic [37:0] rf_q[$];
    int lat, errors, n_tests, n_req, leaks;

    function automatic logic [31:0] rfv(input logic [5:0] i);
        return {16'hC0DE, 10'h000, i};
    endfunction : rfv

    always #5 clk = ~clk;

    ssq_stack_seq ssq_stack_seq_i (.clk_in(clk), .srst_in(srst), .ce_in(1'b1),
        .cmd_valid_in(cv), .cmd_op_in(op), .cmd_reg_in(rg), .cmd_dlim_in(dlim),
        .cmd_plim_in(plim), .cmd_use_d_in(use_d), .cmd_use_p_in(use_p),
        .cmd_parallel_in(par), .cmd_long_in(lng), .supervisor_in(sup),
        .cmd_ready_out(ready), .done_out(done), .sp_load_en_in(sp_en),
        .sp_load_val_in(sp_val), .stack_ptr_out(sp), .rf_rd_idx_out(rdidx),
        .rf_rd_data_in(rfv(rdidx)), .rf_wr_en_out(rfwe), .rf_wr_idx_out(wridx),
        .rf_wr_data_out(rfwd), .mem_req_out(req), .mem_we_out(we), .mem_addr_out(addr),
        .mem_wdata_out(wdata), .mem_ack_in(ack), .mem_err_in(err), .mem_rdata_in(rdata),
        .irq_in(irq), .irq_deliver_out(deliver), .irq_hold_out(hold), .int_enable_out(ie),
        .exc_valid_out(excv), .exc_code_out(code));
    ssq_mem_model ssq_mem_model_i (.clk_in(clk), .req_in(req), .we_in(we), .addr_in(addr),
        .wdata_in(wdata), .lat_in(lat), .err_addr_in(err_addr), .ack_out(ack),
        .err_out(err), .rdata_out(rdata));

    // ----------------------------------------------------------------
    // Traffic monitor
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (req && ack && we && !err) wr_q.push_back({addr, wdata});
        if (rfwe) rf_q.push_back({wridx, rfwd});
        if (req) n_req++;
        hold_q <= hold;
        // Delivery and hold switch on the same edge; only a second held cycle counts
        if (hold_q && hold && deliver) leaks++;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    task automatic ld(input logic [31:0] v);
        sp_en = 1'b1;
        sp_val = v;
        @(negedge clk);
        sp_en = 1'b0;
    endtask : ld

    // Flags f: use_d, use_p, parallel, long, supervisor
    task automatic issue(input logic [1:0] o, input logic [5:0] r, input logic [2:0] dl,
        input logic [2:0] pl, input logic [4:0] f, output logic [2:0] xc);
        int i;
        i = 0;
        while (ready !== 1'b1 && i < 50) begin
            @(negedge clk);
            i++;
        end
        {use_d, use_p, par, lng, sup} = f;
        op = o;
        rg = r;
        dlim = dl;
        plim = pl;
        cv = 1'b1;
        @(negedge clk);
        cv = 1'b0;
        xc = EXC_NONE;
        i = 0;
        while (done !== 1'b1 && excv !== 1'b1 && i < 200) begin
            @(negedge clk);
            i++;
        end
        if (excv === 1'b1) xc = code;
        chk(i < 200, "no completion");
        @(negedge clk);
    endtask : issue

    task automatic rej(input logic [1:0] o, input logic [5:0] r, input logic [2:0] pl,
        input logic [4:0] f, input logic [2:0] ex);
        logic [2:0] x;
        int n0;
        logic [31:0] s0;
        n0 = n_req;
        s0 = sp;
        issue(o, r, 3'h0, pl, f, x);
        chk(x === ex && n_req == n0 && sp === s0, "reject outcome");
    endtask : rej

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reject;
        ld(32'h0000_0100);
        rej(OP_PUSH, 6'h03, 3'h0, 5'b00101, EXC_UNDEF);
        rej(OP_POP, 6'h03, 3'h0, 5'b00011, EXC_UNDEF);
        rej(OP_POP, REG_STACK_PTR, 3'h0, 5'b00001, EXC_UNDEF);
        rej(OP_PUSHM, 6'h00, 3'h6, 5'b01001, EXC_UNDEF);
        rej(OP_POPM, 6'h00, 3'h0, 5'b00001, EXC_UNDEF);
        for (int r = 17; r <= 23; r++) begin
            rej(OP_PUSH, 6'(r), 3'h0, 5'b00000, EXC_PROT);
            rej(OP_POP, 6'(r), 3'h0, 5'b00000, EXC_PROT);
        end
        ld(32'h0000_0102);
        rej(OP_PUSH, 6'h01, 3'h0, 5'b00001, EXC_ALIGN);
        rej(OP_POPM, 6'h00, 3'h2, 5'b11001, EXC_ALIGN);
    endtask : t_reject

    task automatic t_single;
        logic [2:0] x;
        ld(32'h0000_0100);
        lat = 2;
        issue(OP_PUSH, 6'h03, 3'h0, 3'h0, 5'b00000, x);
        chk(x === EXC_NONE && sp === 32'h0000_00FC, "push sp");
        chk(ssq_mem_model_i.mem[8'h3F] === rfv(6'h03), "push data");
        rf_q.delete();
        issue(OP_POP, 6'h05, 3'h0, 3'h0, 5'b00000, x);
        chk(sp === 32'h0000_0100 && rf_q.size() == 1, "pop sp");
        chk(rf_q[0] === {6'h05, rfv(6'h03)}, "pop data");
        chk(ssq_mem_model_i.mem[8'h3F] === rfv(6'h03), "pop keeps word");
    endtask : t_single

    task automatic t_inten;
        logic [2:0] x;
        issue(OP_PUSH, REG_INT_RET, 3'h0, 3'h0, 5'b00001, x);
        chk(ie === 1'b1, "int ret push enables");
        issue(OP_PUSH, REG_SUBR_RET, 3'h0, 3'h0, 5'b00000, x);
        chk(ie === 1'b1, "subr ret push");
        issue(OP_POP, REG_SUBR_RET, 3'h0, 3'h0, 5'b00000, x);
        chk(ie === 1'b1, "subr ret pop");
    endtask : t_inten

    task automatic t_multi;
        logic [2:0] x;
        logic [5:0] ix [5] = '{6'h05, 6'h06, 6'h07, 6'h0C, 6'h0D};
        ld(32'h0000_0200);
        lat = 0;
        irq = 1'b1;
        wr_q.delete();
        issue(OP_PUSHM, 6'h00, 3'h5, 3'h4, 5'b11001, x);
        chk(wr_q.size() == 5 && sp === 32'h0000_01EC, "push multiple count");
        for (int k = 0; k < 5; k++) begin
            chk(wr_q[k] === {32'h0000_01FC - 32'(4 * k), rfv(ix[k])}, "push order");
        end
        chk(leaks == 0 && deliver === 1'b1, "irq held then delivered");
        irq = 1'b0;
        rf_q.delete();
        lat = 1;
        issue(OP_POPM, 6'h00, 3'h5, 3'h4, 5'b11001, x);
        chk(rf_q.size() == 5 && sp === 32'h0000_0200, "pop multiple sp");
        for (int k = 0; k < 5; k++) begin
            chk(rf_q[k] === {ix[4 - k], rfv(ix[4 - k])}, "pop order");
        end
    endtask : t_multi

    task automatic t_fault;
        logic [2:0] x;
        ld(32'h0000_00FC);
        issue(OP_POP, REG_INT_RET, 3'h0, 3'h0, 5'b00001, x);
        chk(ie === 1'b0, "int ret pop disables");
        ld(32'h0000_0300);
        err_addr = 32'h0000_02F8;
        issue(OP_PUSHM, 6'h00, 3'h5, 3'h0, 5'b10001, x);
        chk(x === EXC_BUS && sp === 32'h0000_0300, "abort restores sp");
        chk(ssq_mem_model_i.mem[8'hBF] === rfv(6'h05), "first store kept");
        err_addr = 32'hFFFF_FFFF;
    endtask : t_fault

    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    task automatic end_sim;
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        {clk, srst, cv, use_d, use_p, par, lng, sup, sp_en, irq} = 10'b01_0000_0000;
        {op, rg, dlim, plim, sp_val, err_addr} = {14'h0, 32'h0, 32'hFFFF_FFFF};
        {lat, errors, n_tests, n_req, leaks} = '0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        t_reject;
        t_single;
        t_inten;
        t_multi;
        t_fault;
        end_sim;
    end

    initial begin
        #100000;
        errors++;
        end_sim;
    end
endmodule : tb
